// file: rtl/tap_memory_programming_port.sv
// Purpose: test-port data registers for reset, unlock, commands, page io
// Assumes: tck is free of i_mclk; memory answers on the tck side
// Notes:   tdo output enable is low while driving
//          fuse and external reset pins pass two chip-clock flops
//          unlock flag reaches the chip clock through two flops
// Contract
// - programming works only with access fuse set and disable bit clear
// - disable bit set with external reset low clears after two chip clocks
// - all chains shift least significant bit first
// - instruction register is four bits wide
// - run-test/idle makes internal strobes
// - opcode 0xc selects one-bit reset chain, tap not reset
// - reset chain one holds device in reset, unlatched
// - opcode 0x4 selects 16-bit unlock register
// - update-dr compares unlock value, enters programming on match
// - expected signature is 1010_0011_0111_0000
// - unlock register clears on power-on reset
// - opcode 0x5 selects 15-bit command register
// - capture-dr loads previous command result
// - shift-dr shifts result out while command shifts in
// - update-dr applies command to memory inputs
// - passing run-test/idle gives one execute strobe
// - opcode 0x6 selects 1024-bit page-fill chain from 8-bit shifter
// - page fill writes each byte during shift-dr, update does nothing
// - opcode 0x7 selects 1032-bit page-dump chain, no capture
// - page dump shifts flash bytes out, ignores tdi
// - reset holds for the time-out after reset chain release
`timescale 1ns/1ps
`default_nettype none

module tap_memory_programming_port (
    // chip clock domain
    input  wire logic                   i_mclk,
    input  wire logic                   i_reset,
    input  wire logic                   i_ext_reset_n,
    input  wire logic                   i_tap_access_fuse,
    input  wire logic                   i_tap_disable_set,
    output logic                        o_tap_disable_bit,
    output logic                        o_device_reset,
    output logic                        o_prog_mode,
    // test pins
    input  wire logic                   i_tck,
    input  wire logic                   i_tms,
    input  wire logic                   i_tdi,
    output logic                        o_tdo,
    output logic                        o_tdo_oe_n,
    // memory side, tck domain
    output tap_prog_pkg::mem_cmd_t      o_mem_cmd,
    output logic                        o_mem_exec,
    input  wire logic [14:0]            i_mem_result,
    output tap_prog_pkg::page_wr_t      o_page_wr,
    output logic [6:0]                  o_page_rd_addr,
    input  wire logic [7:0]             i_page_rd_data
);
    import tap_prog_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // chip clock: disable bit and reset stretch
    logic [1:0] ext_sync_ff;
    logic [1:0] dis_cnt_ff;
    logic       tap_disable_ff;
    logic [1:0] rst_sync_ff;
    logic [6:0] rst_cnt_ff;
    logic       rst_chain_ff;
    logic       unlock_ok_ff;
    logic       tap_en;
    logic [1:0] en_sync_ff;
    logic [1:0] fuse_sync_ff;
    logic [1:0] prog_sync_ff;

    // external reset pin, two flops
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            ext_sync_ff <= 2'h3;
        end else begin
            ext_sync_ff <= {ext_sync_ff[0], i_ext_reset_n};
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            fuse_sync_ff <= 2'h0;
        end else begin
            fuse_sync_ff <= {fuse_sync_ff[0], i_tap_access_fuse};
        end
    end

    // a set in the same cycle as the clear wins
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            tap_disable_ff <= 1'b0;
            dis_cnt_ff     <= 2'h0;
        end else if (i_tap_disable_set) begin
            tap_disable_ff <= 1'b1;
            dis_cnt_ff     <= 2'h0;
        end else if (tap_disable_ff && !ext_sync_ff[1]) begin
            if (dis_cnt_ff == 2'(DISABLE_CLR_CYC - 1)) begin
                tap_disable_ff <= 1'b0;
                dis_cnt_ff     <= 2'h0;
            end else begin
                dis_cnt_ff <= dis_cnt_ff + 2'h1;
            end
        end else begin
            dis_cnt_ff <= 2'h0;
        end
    end

    assign o_tap_disable_bit = tap_disable_ff;
    assign tap_en = fuse_sync_ff[1] && !tap_disable_ff;

    // reset chain level crosses into chip clock
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], rst_chain_ff};
        end
    end

    // time-out restarts while the chain bit is seen
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            rst_cnt_ff <= 7'h00;
        end else if (rst_sync_ff[1]) begin
            rst_cnt_ff <= 7'(RST_TIMEOUT_CYC);
        end else if (rst_cnt_ff != 7'h00) begin
            rst_cnt_ff <= rst_cnt_ff - 7'h01;
        end
    end

    // chain bit acts at once, stretch covers the time-out
    assign o_device_reset = rst_chain_ff || rst_sync_ff[1]
                            || (rst_cnt_ff != 7'h00);

    // unlock flag crosses from tck into chip clock
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            prog_sync_ff <= 2'h0;
        end else begin
            prog_sync_ff <= {prog_sync_ff[0], unlock_ok_ff};
        end
    end

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            o_prog_mode <= 1'b0;
        end else begin
            o_prog_mode <= prog_sync_ff[1] && tap_en;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // tck domain: tap controller
    tap_state_t st_ff;
    tap_state_t nxt_st;
    logic [3:0] ir_ff;
    logic [3:0] ir_sh_ff;

    // enable crosses into tck; tap sits in reset while off
    always_ff @(posedge i_tck or posedge i_reset) begin
        if (i_reset) begin
            en_sync_ff <= 2'h0;
        end else begin
            en_sync_ff <= {en_sync_ff[0], tap_en};
        end
    end

    always_comb begin
        unique case (st_ff)
            ST_TLR:    nxt_st = i_tms ? ST_TLR    : ST_RTI;
            ST_RTI:    nxt_st = i_tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: nxt_st = i_tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: nxt_st = i_tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  nxt_st = i_tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: nxt_st = i_tms ? ST_UP_DR  : ST_PA_DR;
            ST_PA_DR:  nxt_st = i_tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: nxt_st = i_tms ? ST_UP_DR  : ST_SH_DR;
            ST_UP_DR:  nxt_st = i_tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: nxt_st = i_tms ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR: nxt_st = i_tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  nxt_st = i_tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: nxt_st = i_tms ? ST_UP_IR  : ST_PA_IR;
            ST_PA_IR:  nxt_st = i_tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: nxt_st = i_tms ? ST_UP_IR  : ST_SH_IR;
            ST_UP_IR:  nxt_st = i_tms ? ST_SEL_DR : ST_RTI;
            default:   nxt_st = ST_TLR;
        endcase
    end

    always_ff @(posedge i_tck or posedge i_reset) begin
        if (i_reset) begin
            st_ff <= ST_TLR;
        end else if (!en_sync_ff[1]) begin
            st_ff <= ST_TLR;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // instruction register; ir selection never resets the controller
    always_ff @(posedge i_tck or posedge i_reset) begin
        if (i_reset) begin
            ir_sh_ff <= IR_RESET_VAL;
        end else if (st_ff == ST_CAP_IR) begin
            ir_sh_ff <= 4'h1;
        end else if (st_ff == ST_SH_IR) begin
            ir_sh_ff <= {i_tdi, ir_sh_ff[IR_W-1:1]};
        end
    end

    // decoded instruction, loaded on update-ir
    always_ff @(posedge i_tck or posedge i_reset) begin
        if (i_reset) begin
            ir_ff <= IR_RESET_VAL;
        end else if (st_ff == ST_TLR) begin
            ir_ff <= IR_RESET_VAL;
        end else if (st_ff == ST_UP_IR) begin
            ir_ff <= ir_sh_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data registers
    logic [15:0] unlock_sh_ff;
    logic [14:0] cmd_sh_ff;
    logic [7:0]  page_sh_ff;
    logic [2:0]  bit_cnt_ff;
    logic [6:0]  byte_cnt_ff;
    logic        prog_ok;
    logic        sel_cmd;
    logic        sel_fill;
    logic        sel_dump;
    logic        upd_pend_ff;

    // one lsb-first step of the 8-bit page shifter
    function automatic logic [7:0] shift8(input logic [7:0] cur,
                                          input logic       din);
        return {din, cur[7:1]};
    endfunction

    // command and page chains answer only after a good unlock
    assign prog_ok  = unlock_ok_ff && en_sync_ff[1];
    assign sel_cmd  = (ir_ff == OP_COMMAND)   && prog_ok;
    assign sel_fill = (ir_ff == OP_PAGE_FILL) && prog_ok;
    assign sel_dump = (ir_ff == OP_PAGE_DUMP) && prog_ok;

    // reset chain bit drives device reset without a latch
    always_ff @(posedge i_tck or posedge i_reset) begin
        if (i_reset) begin
            rst_chain_ff <= 1'b0;
        end else if (ir_ff == OP_RESET && st_ff == ST_SH_DR) begin
            rst_chain_ff <= i_tdi;
        end
    end

    // flag follows every unlock update, a bad signature locks again
    always_ff @(posedge i_tck or posedge i_reset) begin
        if (i_reset) begin
            unlock_sh_ff <= UNLOCK_RST;
            unlock_ok_ff <= 1'b0;
        end else if (ir_ff == OP_UNLOCK) begin
            if (st_ff == ST_SH_DR) begin
                unlock_sh_ff <= {i_tdi, unlock_sh_ff[UNLOCK_W-1:1]};
            end else if (st_ff == ST_UP_DR) begin
                unlock_ok_ff <= (unlock_sh_ff == UNLOCK_SIG);
            end
        end
    end

    // command chain: capture result, shift lsb first
    always_ff @(posedge i_tck or posedge i_reset) begin
        if (i_reset) begin
            cmd_sh_ff <= CMD_RST;
        end else if (sel_cmd && st_ff == ST_CAP_DR) begin
            cmd_sh_ff <= i_mem_result;
        end else if (sel_cmd && st_ff == ST_SH_DR) begin
            cmd_sh_ff <= {i_tdi, cmd_sh_ff[CMD_W-1:1]};
        end
    end

    // apply on update, one execute strobe in the next run-test/idle
    always_ff @(posedge i_tck or posedge i_reset) begin
        if (i_reset) begin
            o_mem_cmd   <= '0;
            upd_pend_ff <= 1'b0;
            o_mem_exec  <= 1'b0;
        end else begin
            o_mem_exec <= 1'b0;
            if (sel_cmd && st_ff == ST_UP_DR) begin
                o_mem_cmd   <= '{valid: 1'b1, word: cmd_sh_ff};
                upd_pend_ff <= 1'b1;
            end else if (st_ff == ST_RTI && upd_pend_ff) begin
                o_mem_exec  <= 1'b1;
                upd_pend_ff <= 1'b0;
            end else if (st_ff != ST_RTI && st_ff != ST_UP_DR) begin
                upd_pend_ff <= upd_pend_ff && (st_ff != ST_TLR);
            end
        end
    end

    // page chains: 8-bit shifter with bit and byte counters
    always_ff @(posedge i_tck or posedge i_reset) begin
        if (i_reset) begin
            page_sh_ff  <= 8'h00;
            bit_cnt_ff  <= 3'h0;
            byte_cnt_ff <= 7'h00;
            o_page_wr   <= '0;
        end else begin
            o_page_wr.wr <= 1'b0;
            if ((sel_fill || sel_dump) && st_ff == ST_CAP_DR) begin
                bit_cnt_ff  <= 3'h0;
                byte_cnt_ff <= 7'h00;
                page_sh_ff  <= 8'h00;
            end else if (sel_fill && st_ff == ST_SH_DR) begin
                page_sh_ff <= shift8(page_sh_ff, i_tdi);
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                if (bit_cnt_ff == 3'h7) begin
                    o_page_wr <= '{wr: 1'b1, addr: byte_cnt_ff,
                                   data: shift8(page_sh_ff, i_tdi)};
                    byte_cnt_ff <= byte_cnt_ff + 7'h01;
                end
            // slot zero shifts out zeros while byte 0 is fetched
            end else if (sel_dump && st_ff == ST_SH_DR) begin
                bit_cnt_ff <= bit_cnt_ff + 3'h1;
                if (bit_cnt_ff == 3'h7) begin
                    page_sh_ff  <= i_page_rd_data;
                    byte_cnt_ff <= byte_cnt_ff + 7'h01;
                end else begin
                    page_sh_ff <= {1'b0, page_sh_ff[7:1]};
                end
            end
        end
    end

    assign o_page_rd_addr = byte_cnt_ff;

    ////////////////////////////////////////////////////////////////////
    // tdo, changes on falling tck
    // falling launch gives the programmer half a tck of setup
    logic tdo_bit;

    always_comb begin
        tdo_bit = 1'b0;
        if (st_ff == ST_SH_IR) begin
            tdo_bit = ir_sh_ff[0];
        end else if (st_ff == ST_SH_DR) begin
            unique case (ir_ff)
                OP_RESET:     tdo_bit = rst_chain_ff;
                OP_UNLOCK:    tdo_bit = unlock_sh_ff[0];
                OP_COMMAND:   tdo_bit = cmd_sh_ff[0];
                OP_PAGE_FILL: tdo_bit = page_sh_ff[0];
                OP_PAGE_DUMP: tdo_bit = page_sh_ff[0];
                default:      tdo_bit = 1'b0;
            endcase
        end
    end

    always_ff @(negedge i_tck or posedge i_reset) begin
        if (i_reset) begin
            o_tdo      <= 1'b0;
            o_tdo_oe_n <= 1'b1;
        end else begin
            o_tdo      <= tdo_bit;
            o_tdo_oe_n <= !(st_ff == ST_SH_DR || st_ff == ST_SH_IR);
        end
    end

endmodule

`default_nettype wire

// file: inc/tap_prog_pkg.sv
// Purpose: constants and carriers for the test-port programming block
// Assumes: tap state and instruction decode arrive from the test-clock side
// Notes:   all shift chains move lsb first
package tap_prog_pkg;

    localparam int          IR_W           = 4;
    localparam logic [3:0]  OP_RESET       = 4'hc;
    localparam logic [3:0]  OP_UNLOCK      = 4'h4;
    localparam logic [3:0]  OP_COMMAND     = 4'h5;
    localparam logic [3:0]  OP_PAGE_FILL   = 4'h6;
    localparam logic [3:0]  OP_PAGE_DUMP   = 4'h7;
    localparam logic [3:0]  IR_RESET_VAL   = 4'hf;

    localparam int          UNLOCK_W       = 16;
    localparam logic [15:0] UNLOCK_SIG     = 16'ha370;
    localparam logic [15:0] UNLOCK_RST     = 16'h0000;
    localparam int          CMD_W          = 15;
    localparam logic [14:0] CMD_RST        = 15'h0000;
    localparam int          PAGE_BYTES     = 128;
    localparam int          PAGE_AW        = 7;
    localparam int          DISABLE_CLR_CYC = 2;
    localparam int          RST_TIMEOUT_CYC = 64;

    // tap controller states, one-hot
    typedef enum logic [15:0] {
        ST_TLR    = 16'h0001,
        ST_RTI    = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR  = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PA_DR  = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UP_DR  = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR  = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PA_IR  = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UP_IR  = 16'h8000
    } tap_state_t;

    typedef struct packed {
        logic        valid;
        logic [14:0] word;
    } mem_cmd_t;

    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] data;
    } page_wr_t;

endpackage

// file: bench/tap_prog_asserts.sv
// Purpose: port checks of the programming block
// Assumes: bound by port name
// Notes:   two clock domains
`timescale 1ns/1ps
`default_nettype none
module tap_prog_asserts (
    // chip clock side
    input wire logic                   i_mclk,
    input wire logic                   i_reset,
    input wire logic                   i_ext_reset_n,
    input wire logic                   i_tap_access_fuse,
    input wire logic                   i_tap_disable_set,
    input wire logic                   o_tap_disable_bit,
    input wire logic                   o_device_reset,
    input wire logic                   o_prog_mode,
    // test clock side
    input wire logic                   i_tck,
    input wire logic                   o_mem_exec,
    input wire tap_prog_pkg::mem_cmd_t o_mem_cmd,
    input wire tap_prog_pkg::page_wr_t o_page_wr
);
    import tap_prog_pkg::*;
    logic [7:0] hi_cnt_ff;
    // cycles the device reset has stood high
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset || !o_device_reset) begin
            hi_cnt_ff <= 8'h00;
        end else if (hi_cnt_ff != 8'hff) begin
            hi_cnt_ff <= hi_cnt_ff + 8'h01;
        end
    end
    a_disable_set: assert property (@(posedge i_mclk) disable iff (i_reset)
        i_tap_disable_set |=> o_tap_disable_bit) else $error("no set");
    a_disable_clear: assert property (@(posedge i_mclk) disable iff (i_reset)
        o_tap_disable_bit && !i_ext_reset_n && !i_tap_disable_set |-> ##[1:6]
        (!o_tap_disable_bit || i_ext_reset_n || i_tap_disable_set))
        else $error("disable bit not cleared");
    a_reset_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
        $fell(o_device_reset) |-> int'(hi_cnt_ff) >= RST_TIMEOUT_CYC)
        else $error("reset released early");
    a_prog_fuse: assert property (@(posedge i_mclk) disable iff (i_reset)
        $rose(o_prog_mode) |-> i_tap_access_fuse) else $error("no fuse");
    a_exec_pulse: assert property (@(posedge i_tck) disable iff (i_reset)
        o_mem_exec |=> !o_mem_exec) else $error("exec too long");
    a_exec_valid: assert property (@(posedge i_tck) disable iff (i_reset)
        o_mem_exec |-> o_mem_cmd.valid) else $error("exec without command");
    a_wr_spacing: assert property (@(posedge i_tck) disable iff (i_reset)
        o_page_wr.wr |=> !o_page_wr.wr [*7]) else $error("byte write spacing");
    a_wr_step: assert property (@(posedge i_tck) disable iff (i_reset)
        $rose(o_page_wr.wr) && o_page_wr.addr != 7'h00 |->
        o_page_wr.addr == $past(o_page_wr.addr, 8) + 7'h01)
        else $error("page address step");
endmodule
bind tap_memory_programming_port tap_prog_asserts u_chk (.*);
`default_nettype wire

// file: bench/tap_host.sv
// Purpose: programmer model on the four test pins
// Assumes: sole device on the scan chain
// Notes:   tck stands still between scans
`timescale 1ns/1ps
`default_nettype none
module tap_host (
    // test pins
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi,
    input  wire logic i_tdo
);
    logic last = 1'b0;
    initial o_tck = 1'b0;
    initial o_tms = 1'b1;
    initial o_tdi = 1'b0;
    // one 64 ns tck, tdo read while low
    task automatic tick(input logic ms, input logic di, output logic dq);
        o_tms = ms;
        o_tdi = di;
        last = di;
        #16 dq = i_tdo;
        o_tck = 1'b1;
        #32 o_tck = 1'b0;
        #16;
    endtask
    // tdi toggles when not shifting
    task automatic idle(input int n, input logic ms);
        logic dq;
        repeat (n) tick(ms, ~last, dq);
    endtask
    task automatic scan(input logic ir, input int n, input logic [1031:0] d,
                        output logic [1031:0] q);
        q = '0;
        idle(ir ? 2 : 1, 1'b1);
        idle(2, 1'b0);
        for (int i = 0; i < n; i++) tick(i == n - 1, d[i], q[i]);
        idle(1, 1'b1);
        idle(1, 1'b0);
    endtask
endmodule
`default_nettype wire

// file: bench/tap_memory_programming_port_tb.sv
// Purpose: directed scans of reset, unlock, command and page chains
// Assumes: access fuse programmed
// Notes:   page read data is a fixed table of the address
`timescale 1ns/1ps
`default_nettype none
module tap_memory_programming_port_tb;
    import tap_prog_pkg::*;
    logic          i_mclk, i_reset, i_ext_reset_n, i_tap_access_fuse;
    logic          i_tap_disable_set, o_tap_disable_bit, o_device_reset;
    logic          o_prog_mode, i_tck, i_tms, i_tdi, o_tdo, o_tdo_oe_n;
    logic          o_mem_exec;
    logic [14:0]   i_mem_result;
    logic [6:0]    o_page_rd_addr;
    logic [7:0]    i_page_rd_data;
    mem_cmd_t      o_mem_cmd;
    page_wr_t      o_page_wr;
    logic [1031:0] d, q;
    int            err_total = 0, n_checks = 0, wr_cnt = 0, ex_cnt = 0;
    tap_memory_programming_port uut (.*);
    tap_host host (.o_tck(i_tck), .o_tms(i_tms), .o_tdi(i_tdi), .i_tdo(o_tdo));
    assign i_page_rd_data = {1'b1, o_page_rd_addr} ^ 8'h96;
    initial begin
        i_mclk = 1'b0;
        forever #10 i_mclk = ~i_mclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic ir(input logic [3:0] op);
        host.scan(1'b1, 4, {1028'h0, op}, q);
    endtask
    task automatic unlock(input logic [15:0] s);
        ir(OP_UNLOCK);
        host.scan(1'b0, 16, {1016'h0, s}, q);
        repeat (8) @(negedge i_mclk);
    endtask
    task automatic cmd(input logic [14:0] c, r, input logic on);
        @(posedge i_mclk);
        i_mem_result <= r;
        ir(OP_COMMAND);
        ex_cnt = 0;
        host.scan(1'b0, 15, {1017'h0, c}, q);
        host.idle(2, 1'b0);
        check(ex_cnt, on);
        if (on) begin
            check(q[14:0], r);
            check(o_mem_cmd, {1'b1, c});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge i_tck) begin
        if (o_mem_exec === 1'b1) ex_cnt++;
        if (o_page_wr.wr === 1'b1) begin
            check(o_page_wr.addr, wr_cnt);
            check(o_page_wr.data, wr_cnt[7:0] ^ 8'h3c);
            wr_cnt++;
        end
    end
    initial begin
        #500000;
        err_total++;
        summarize();
    end
    initial begin
        i_reset = 1'b1;
        i_ext_reset_n = 1'b1;
        i_tap_access_fuse = 1'b1;
        i_tap_disable_set = 1'b0;
        i_mem_result = 15'h0000;
        host.idle(2, 1'b1);
        repeat (3) @(posedge i_mclk);
        i_reset <= 1'b0;
        @(posedge i_mclk);
        check(o_tdo_oe_n, 1);
        i_tap_disable_set <= 1'b1;
        @(posedge i_mclk);
        i_tap_disable_set <= 1'b0;
        i_ext_reset_n <= 1'b0;
        @(negedge i_mclk);
        check(o_tap_disable_bit, 1);
        repeat (7) @(posedge i_mclk);
        i_ext_reset_n <= 1'b1;
        @(negedge i_mclk);
        check(o_tap_disable_bit, 0);
        host.idle(6, 1'b1);
        host.idle(1, 1'b0);
        ir(OP_RESET);
        host.scan(1'b0, 1, 1032'h1, q);
        @(negedge i_mclk);
        check(o_device_reset, 1);
        unlock(UNLOCK_SIG ^ 16'h0001);
        check(o_prog_mode, 0);
        cmd(15'h1111, 15'h0000, 1'b0);
        unlock(UNLOCK_SIG);
        check(o_prog_mode, 1);
        cmd(15'h4c3a, 15'h2b5e, 1'b1);
        cmd(15'h7ffe, 15'h0517, 1'b1);
        ir(OP_PAGE_FILL);
        for (int i = 0; i < 128; i++) d[8*i +: 8] = i[7:0] ^ 8'h3c;
        host.scan(1'b0, 1024, d, q);
        host.idle(2, 1'b0);
        check(wr_cnt, 128);
        ir(OP_PAGE_DUMP);
        host.scan(1'b0, 1032, '1, q);
        check(q[7:0], 0);
        for (int i = 0; i < 128; i++) begin
            check(q[8*i+8 +: 8], {1'b1, i[6:0]} ^ 8'h96);
        end
        unlock(16'h0000);
        check(o_prog_mode, 0);
        ir(OP_RESET);
        host.scan(1'b0, 1, '0, q);
        repeat (40) @(negedge i_mclk);
        check(o_device_reset, 1);
        repeat (30) @(negedge i_mclk);
        check(o_device_reset, 0);
        summarize();
    end
endmodule
`default_nettype wire
